// *** adcsq_far_model.sv ***
`timescale 1ns/1ps
module adcsq_far_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic auto_en,
  input wire logic rc_en,
  input wire logic event_pulse,
  output logic start_sample,
  output logic rc_tick,
  output logic [7:0] event_count
);
  logic [1:0] rc_div_r;
  ////////////////////////////////////////////////////////////////////////////
  // The far side keeps asking for samples while enabled, like auto-start.
  assign start_sample = auto_en;
  // The internal RC clock ticks once every four system cycles.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rc_div_r <= 2'h0;
      rc_tick <= 1'b0;
    end else begin
      rc_div_r <= rc_div_r + 2'h1;
      rc_tick <= rc_en && (rc_div_r == 2'h0);
    end
  end
  // Each event pulse advances the event count by one.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      event_count <= 8'h00;
    end else if (event_pulse) begin
      event_count <= event_count + 8'h01;
    end
  end
endmodule

// *** adcsq_pkg.sv ***
package adcsq_pkg;
  // Register word offsets on the register bus.
  localparam logic [3:0] ADCSQ_OFF_CTRL1 = 4'h0;
  localparam logic [3:0] ADCSQ_OFF_CTRL2 = 4'h1;
  localparam logic [3:0] ADCSQ_OFF_CTRL3 = 4'h2;
  localparam logic [3:0] ADCSQ_OFF_CTRL4 = 4'h3;
  localparam logic [3:0] ADCSQ_OFF_CH13 = 4'h4;
  localparam logic [3:0] ADCSQ_OFF_CH0 = 4'h5;
  localparam logic [3:0] ADCSQ_OFF_SCAN = 4'h6;
  localparam logic [3:0] ADCSQ_OFF_STAT = 4'h7;
  // Field positions.
  localparam int ADCSQ_RES_BIT = 10;
  localparam int ADCSQ_SCAN_EN_BIT = 10;
  localparam int ADCSQ_CHPS_LSB = 8;
  localparam int ADCSQ_FILL_BIT = 7;
  localparam int ADCSQ_SMPI_LSB = 2;
  localparam int ADCSQ_SPLIT_BIT = 1;
  localparam int ADCSQ_ALT_BIT = 0;
  localparam int ADCSQ_SRC_BIT = 15;
  localparam int ADCSQ_SAMC_LSB = 8;
  // Writable bit masks, reset value.
  localparam logic [15:0] ADCSQ_MASK_CTRL1 = 16'h0400;
  localparam logic [15:0] ADCSQ_MASK_CTRL2 = 16'h073F;
  localparam logic [15:0] ADCSQ_MASK_CTRL3 = 16'h9FFF;
  localparam logic [15:0] ADCSQ_MASK_CTRL4 = 16'h0007;
  localparam logic [15:0] ADCSQ_MASK_CH13 = 16'h0707;
  localparam logic [15:0] ADCSQ_MASK_CH0 = 16'h9F9F;
  localparam logic [15:0] ADCSQ_MASK_SCAN = 16'h01FF;
  localparam logic [15:0] ADCSQ_RST_VAL = 16'h0000;
  localparam logic [3:0] ADCSQ_HALF_HI = 4'h8;
  localparam logic [3:0] ADCSQ_HALF_LO = 4'h0;
  localparam logic [7:0] ADCSQ_DIV_RSVD = 8'hFF;
  localparam logic [4:0] ADCSQ_AN_ONE = 5'h01;
  localparam int ADCSQ_NUM_IN = 9;
  // Sequencer states.
  typedef enum logic [2:0] {
    ADCSQ_IDLE = 3'b001,
    ADCSQ_SAMPLE = 3'b010,
    ADCSQ_CONVERT = 3'b100
  } adcsq_state_t;
endpackage

// *** adcsq_scan_pick.sv ***
`timescale 1ns/1ps
module adcsq_scan_pick #(
  parameter int NUM_IN = 9
) (
  input wire logic [NUM_IN-1:0] mask,
  input wire logic [3:0] cur,
  output logic [3:0] next_in,
  output logic [3:0] first_in,
  output logic any_sel
);
  logic [NUM_IN-1:0] above;
  logic [3:0] nxt_above;
  logic found_above;

  // Bits strictly above the current input.
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_above
      assign above[g] = mask[g] && (g > cur);
    end
  endgenerate

  // Lowest selected input overall and lowest one above the current input.
  always_comb begin
    first_in = 4'h0;
    nxt_above = 4'h0;
    found_above = 1'b0;
    any_sel = |mask;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (mask[i]) begin
        first_in = 4'(i);
      end
      if (above[i]) begin
        nxt_above = 4'(i);
        found_above = 1'b1;
      end
    end
    next_in = found_above ? nxt_above : first_in;
  end
endmodule

// *** adcsq_top.sv ***
`timescale 1ns/1ps
// What this block does
// - Resolution bit set: one channel 12-bit; clear: one, two or four channels 10-bit.
// - Scan enable steps channel 0 Sample A input through masked inputs.
// - Channels-utilized picks channel count; reads zero in 12-bit mode.
// - Fill status reads 1 while upper half fills, 0 for lower.
// - Event every samples_per_event plus one completed conversions.
// - Scan list restarts at its first input on each event that ends a Sample A conversion.
// - Clock source clear: conversion clock from divided instruction clock.
// - Divider ignored when the internal RC clock is selected.
// - Auto sample time lasts field value conversion clock periods.
// - DMA words per input are two to the field value.
// - Channels 1-3 negative codes 00/01 low reference, 10 inputs 6-8.
// - Channels 1-3 positive bit picks inputs 3-5 or 0-2.
// - Channel 0 positive fields route input number equal to code.
// - Scan mask bit set includes its input, clear skips it.
// - Mask bits stay writable; missing inputs convert low reference.
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int CONV_CYCLES = 14,
  parameter int NUM_IN = 9,
  parameter logic [3:0] TOP_INPUT = 4'h8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rc_tick,
  input wire logic start_sample,
  output logic conv_start,
  output logic conv_twelve_bit,
  output logic [2:0] conv_channels,
  output logic [3:0] ch0_pos_input,
  output logic ch0_pos_low_ref,
  output logic ch0_neg_input_one,
  output logic [3:0] ch13_pos_base,
  output logic ch13_neg_inputs,
  output logic ch13_neg_rsvd,
  output logic [3:0] result_slot,
  output logic [7:0] dma_words_per_input,
  output logic event_pulse
);
  import adcsq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] ctrl1_r, ctrl2_r, ctrl3_r, ctrl4_r, ch13_r, ch0_r, scan_r;
  logic ack_r;
  logic [15:0] rd_nxt;
  logic res12;
  logic acc;

  assign acc = (avs_read || avs_write) && !ack_r;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  // Every access takes one wait cycle; the answer comes on the next edge.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl1_r <= ADCSQ_RST_VAL;
      ctrl2_r <= ADCSQ_RST_VAL;
      ctrl3_r <= ADCSQ_RST_VAL;
      ctrl4_r <= ADCSQ_RST_VAL;
      ch13_r <= ADCSQ_RST_VAL;
      ch0_r <= ADCSQ_RST_VAL;
      scan_r <= ADCSQ_RST_VAL;
    end else if (avs_write && ack_r) begin
      unique case (avs_address)
        ADCSQ_OFF_CTRL1: ctrl1_r <= avs_writedata[15:0] & ADCSQ_MASK_CTRL1;
        ADCSQ_OFF_CTRL2: ctrl2_r <= avs_writedata[15:0] & ADCSQ_MASK_CTRL2;
        ADCSQ_OFF_CTRL3: ctrl3_r <= avs_writedata[15:0] & ADCSQ_MASK_CTRL3;
        ADCSQ_OFF_CTRL4: ctrl4_r <= avs_writedata[15:0] & ADCSQ_MASK_CTRL4;
        ADCSQ_OFF_CH13: ch13_r <= avs_writedata[15:0] & ADCSQ_MASK_CH13;
        ADCSQ_OFF_CH0: ch0_r <= avs_writedata[15:0] & ADCSQ_MASK_CH0;
        ADCSQ_OFF_SCAN: scan_r <= avs_writedata[15:0] & ADCSQ_MASK_SCAN;
        default: ;
      endcase
    end
  end

  assign res12 = ctrl1_r[ADCSQ_RES_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state.
  adcsq_state_t state_r;
  logic fill_hi_r;
  logic use_b_r;
  logic [3:0] smp_cnt_r;
  logic [3:0] slot_r;
  logic [3:0] scan_cur_r;
  logic scan_started_r;
  logic [7:0] div_cnt_r;
  logic tad_tick;
  logic [4:0] samc_cnt_r;
  logic [7:0] conv_cnt_r;
  logic done_evt;
  logic last_smp;
  logic [3:0] scan_next, scan_first;
  logic scan_any;
  logic [3:0] smpi;
  logic [7:0] divv;

  assign smpi = ctrl2_r[ADCSQ_SMPI_LSB +: 4];
  assign divv = ctrl3_r[7:0];

  always_comb begin
    rd_nxt = 16'h0000;
    unique case (avs_address)
      ADCSQ_OFF_CTRL1: rd_nxt = ctrl1_r;
      // Channel count field reads zero in 12-bit mode.
      ADCSQ_OFF_CTRL2: rd_nxt = {ctrl2_r[15:10], res12 ? 2'h0 : ctrl2_r[9:8],
                                  fill_hi_r & ctrl2_r[ADCSQ_SPLIT_BIT], ctrl2_r[6:0]};
      ADCSQ_OFF_CTRL3: rd_nxt = ctrl3_r;
      ADCSQ_OFF_CTRL4: rd_nxt = ctrl4_r;
      ADCSQ_OFF_CH13: rd_nxt = ch13_r;
      ADCSQ_OFF_CH0: rd_nxt = ch0_r;
      ADCSQ_OFF_SCAN: rd_nxt = scan_r;
      ADCSQ_OFF_STAT: rd_nxt = {9'h000, use_b_r, scan_cur_r, state_r == ADCSQ_IDLE,
                                fill_hi_r};
      default: rd_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (acc && avs_read) begin
      avs_readdata <= {16'h0000, rd_nxt};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock: divided instruction clock, or the RC tick.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_cnt_r <= 8'h00;
    end else if (ctrl3_r[ADCSQ_SRC_BIT]) begin
      div_cnt_r <= 8'h00;
    end else if (div_cnt_r >= divv || divv == ADCSQ_DIV_RSVD) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  always_comb begin
    if (ctrl3_r[ADCSQ_SRC_BIT]) begin
      tad_tick = rc_tick;
    end else begin
      tad_tick = (div_cnt_r >= divv) || divv == ADCSQ_DIV_RSVD;
    end
  end

  adcsq_scan_pick #(.NUM_IN(NUM_IN)) u_pick (
    .mask(scan_r[NUM_IN-1:0]),
    .cur(scan_cur_r),
    .next_in(scan_next),
    .first_in(scan_first),
    .any_sel(scan_any)
  );

  assign done_evt = (state_r == ADCSQ_CONVERT) && tad_tick
                    && conv_cnt_r == 8'(CONV_CYCLES - 1);
  assign last_smp = smp_cnt_r == smpi;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= ADCSQ_IDLE;
      samc_cnt_r <= 5'h00;
      conv_cnt_r <= 8'h00;
    end else begin
      unique case (state_r)
        ADCSQ_IDLE: begin
          if (start_sample) begin
            state_r <= ADCSQ_SAMPLE;
            samc_cnt_r <= 5'h00;
          end
        end
        ADCSQ_SAMPLE: begin
          if (samc_cnt_r >= ctrl3_r[ADCSQ_SAMC_LSB +: 5]) begin
            state_r <= ADCSQ_CONVERT;
            conv_cnt_r <= 8'h00;
          end else if (tad_tick) begin
            samc_cnt_r <= samc_cnt_r + 5'h01;
          end
        end
        ADCSQ_CONVERT: begin
          if (done_evt) begin
            state_r <= ADCSQ_IDLE;
          end else if (tad_tick) begin
            conv_cnt_r <= conv_cnt_r + 8'h01;
          end
        end
        default: state_r <= ADCSQ_IDLE;
      endcase
    end
  end

  assign conv_start = (state_r == ADCSQ_SAMPLE)
                      && samc_cnt_r >= ctrl3_r[ADCSQ_SAMC_LSB +: 5];

  // Sample counter, event pulse, fill half and result slot.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      smp_cnt_r <= 4'h0;
      fill_hi_r <= 1'b0;
      slot_r <= ADCSQ_HALF_LO;
      event_pulse <= 1'b0;
    end else begin
      event_pulse <= done_evt && last_smp;
      if (done_evt) begin
        if (last_smp) begin
          smp_cnt_r <= 4'h0;
          fill_hi_r <= ctrl2_r[ADCSQ_SPLIT_BIT] && !fill_hi_r;
          slot_r <= (ctrl2_r[ADCSQ_SPLIT_BIT] && !fill_hi_r) ? ADCSQ_HALF_HI
                                                             : ADCSQ_HALF_LO;
        end else begin
          smp_cnt_r <= smp_cnt_r + 4'h1;
          slot_r <= slot_r + 4'h1;
        end
      end
    end
  end

  // Sample A/B alternation and scan pointer.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      use_b_r <= 1'b0;
      scan_cur_r <= 4'h0;
      scan_started_r <= 1'b0;
    end else begin
      if (!ctrl2_r[ADCSQ_SCAN_EN_BIT]) begin
        scan_started_r <= 1'b0;
      end else if (!scan_started_r) begin
        scan_cur_r <= scan_first;
        scan_started_r <= scan_any;
      end
      if (done_evt) begin
        use_b_r <= ctrl2_r[ADCSQ_ALT_BIT] && !use_b_r;
        if (ctrl2_r[ADCSQ_SCAN_EN_BIT] && scan_started_r && !use_b_r) begin
          scan_cur_r <= last_smp ? scan_first : scan_next;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input routing outputs, registered.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      conv_twelve_bit <= 1'b0;
      conv_channels <= 3'h1;
      ch0_pos_input <= 4'h0;
      ch0_pos_low_ref <= 1'b0;
      ch0_neg_input_one <= 1'b0;
      ch13_pos_base <= 4'h0;
      ch13_neg_inputs <= 1'b0;
      ch13_neg_rsvd <= 1'b0;
      dma_words_per_input <= 8'h01;
    end else begin
      conv_twelve_bit <= res12;
      if (res12 || ctrl2_r[9:8] == 2'b00) begin
        conv_channels <= 3'h1;
      end else if (ctrl2_r[9] == 1'b1) begin
        conv_channels <= 3'h4;
      end else begin
        conv_channels <= 3'h2;
      end
      if (ctrl2_r[ADCSQ_SCAN_EN_BIT] && !use_b_r && scan_started_r) begin
        ch0_pos_input <= scan_cur_r;
        ch0_pos_low_ref <= scan_cur_r > TOP_INPUT;
      end else begin
        ch0_pos_input <= use_b_r ? ch0_r[11:8] : ch0_r[3:0];
        ch0_pos_low_ref <= (use_b_r ? ch0_r[12:8] : ch0_r[4:0]) > 5'(TOP_INPUT);
      end
      ch0_neg_input_one <= use_b_r ? ch0_r[15] : ch0_r[7];
      ch13_pos_base <= (use_b_r ? ch13_r[8] : ch13_r[0]) ? 4'h3 : 4'h0;
      ch13_neg_inputs <= !res12 && (use_b_r ? ch13_r[10:9] : ch13_r[2:1]) == 2'b10;
      ch13_neg_rsvd <= res12 || (use_b_r ? ch13_r[10:9] : ch13_r[2:1]) == 2'b11;
      dma_words_per_input <= 8'h01 << ctrl4_r[2:0];
    end
  end

  assign result_slot = slot_r;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_conv_done;
    done_evt && last_smp;
  endsequence

  AST_EVENT_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    s_conv_done |=> event_pulse)
    else $error("Event pulse missing after final sample.");

  AST_FILL_TOGGLE: assert property (@(posedge mclk) disable iff (!rst_n)
    s_conv_done ##0 ctrl2_r[ADCSQ_SPLIT_BIT] |=> fill_hi_r != $past(fill_hi_r))
    else $error("Fill half did not alternate.");

  AST_FILL_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctrl2_r[ADCSQ_SPLIT_BIT] && done_evt && last_smp |=> slot_r == ADCSQ_HALF_LO)
    else $error("Slot not back to lower half.");

  AST_CHAN_12B: assert property (@(posedge mclk) disable iff (!rst_n)
    res12 |=> conv_channels == 3'h1)
    else $error("12-bit mode must use one channel.");

  AST_DMA_SIZE: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> dma_words_per_input == (8'h01 << $past(ctrl4_r[2:0])))
    else $error("DMA words per input wrong.");

  AST_RC_DIV_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl3_r[ADCSQ_SRC_BIT] |=> div_cnt_r == 8'h00)
    else $error("Divider ran on RC clock.");

  AST_DIV_RANGE: assert property (@(posedge mclk) disable iff (!rst_n)
    div_cnt_r <= divv || $changed(divv))
    else $error("Divider count beyond setting.");

  AST_ALT_AB: assert property (@(posedge mclk) disable iff (!rst_n)
    done_evt && !ctrl2_r[ADCSQ_ALT_BIT] |=> !use_b_r)
    else $error("Sample B used without alternate mode.");

  AST_SAMPLE_TIME: assert property (@(posedge mclk) disable iff (!rst_n)
    state_r == ADCSQ_SAMPLE && samc_cnt_r < ctrl3_r[ADCSQ_SAMC_LSB +: 5] |=> state_r == ADCSQ_SAMPLE)
    else $error("Conversion began before sample time.");
endmodule

// *** adcsq_top_tb.sv ***
`timescale 1ns/1ps
module adcsq_top_tb;
  import adcsq_pkg::*;
  typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} adcsq_row_t;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, auto_en, rc_en, rc_tick;
  logic start_sample, conv_start, conv_twelve_bit, ch0_pos_low_ref, ch0_neg_input_one;
  logic ch13_neg_inputs, ch13_neg_rsvd, event_pulse, cs_q;
  logic [3:0] avs_address, ch0_pos_input, ch13_pos_base, result_slot;
  logic [31:0] avs_writedata, avs_readdata;
  logic [2:0] conv_channels;
  logic [7:0] dma_words_per_input, event_count, ev0;
  logic [15:0] rd;
  logic [3:0] pos_q[$];
  logic lr_q[$];
  int fails, total_checks, cyc;
  int cs_t[$];
  adcsq_row_t rows [0:9] = '{
    '{4'h0, 16'hFFFF, 16'h0400},
    '{4'h1, 16'hFFFF, 16'h043F},
    '{4'h0, 16'h0000, 16'h0000},
    '{4'h1, 16'hFFFF, 16'h073F},
    '{4'h2, 16'hFFFF, 16'h9FFF},
    '{4'h3, 16'hFFFF, 16'h0007},
    '{4'h4, 16'hFFFF, 16'h0707},
    '{4'h5, 16'hFFFF, 16'h9F9F},
    '{4'h6, 16'hFFFF, 16'h01FF},
    '{4'h9, 16'hFFFF, 16'h0000}};

  adcsq_top #(.CONV_CYCLES(4), .NUM_IN(9), .TOP_INPUT(4'h5)) adcsq_top_i (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rc_tick(rc_tick), .start_sample(start_sample),
    .conv_start(conv_start), .conv_twelve_bit(conv_twelve_bit),
    .conv_channels(conv_channels), .ch0_pos_input(ch0_pos_input),
    .ch0_pos_low_ref(ch0_pos_low_ref), .ch0_neg_input_one(ch0_neg_input_one),
    .ch13_pos_base(ch13_pos_base), .ch13_neg_inputs(ch13_neg_inputs),
    .ch13_neg_rsvd(ch13_neg_rsvd), .result_slot(result_slot),
    .dma_words_per_input(dma_words_per_input), .event_pulse(event_pulse));

  adcsq_far_model adcsq_far_model_i (
    .mclk(mclk), .rst_n(rst_n), .auto_en(auto_en), .rc_en(rc_en),
    .event_pulse(event_pulse), .start_sample(start_sample), .rc_tick(rc_tick),
    .event_count(event_count));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Conversion starts are logged at the falling edge, where outputs are settled.
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    cs_q <= conv_start;
    if (rst_n && conv_start === 1'b1 && cs_q !== 1'b1) begin
      pos_q.push_back(ch0_pos_input);
      lr_q.push_back(ch0_pos_low_ref);
      cs_t.push_back(cyc);
    end
    if (cyc == 60000) begin
      fails++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task summarize();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon access; the answer is taken at the rising edge that sees waitrequest low.
  task bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, d};
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    rd = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Registered outputs follow a written register one edge later.
    @(posedge mclk);
    @(negedge mclk);
  endtask

  // Lets the far side request samples until n conversions began, then waits for idle.
  task run(input int n);
    int k;
    k = 0;
    pos_q.delete();
    lr_q.delete();
    cs_t.delete();
    ev0 = event_count;
    @(posedge mclk);
    auto_en <= 1'b1;
    while (pos_q.size() < n && k < 4000) begin
      @(negedge mclk);
      k++;
    end
    @(posedge mclk);
    auto_en <= 1'b0;
    rd = 16'h0000;
    while (rd[1] !== 1'b1 && k < 4400) begin
      bus(1'b0, ADCSQ_OFF_STAT, 16'h0000);
      k++;
    end
    chk("conversions", 16'(n), 16'(pos_q.size()));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    auto_en = 1'b0;
    rc_en = 1'b1;
    cs_q = 1'b0;
    cyc = 0;
    fails = 0;
    total_checks = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk("channels after reset", 16'h0001, 16'(conv_channels));
    chk("dma words after reset", 16'h0001, 16'(dma_words_per_input));
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 16'h0000);
      chk("register readback", rows[i].e, rd);
    end
    chk("channels code 11", 16'h0004, 16'(conv_channels));
    for (int c = 0; c < 2; c++) begin
      bus(1'b1, ADCSQ_OFF_CTRL2, 16'(c << 8));
      chk("channels code", 16'(c + 1), 16'(conv_channels));
    end
    bus(1'b1, ADCSQ_OFF_CTRL1, 16'h0400);
    chk("twelve bit", 16'h0001, 16'(conv_twelve_bit));
    chk("channels twelve bit", 16'h0001, 16'(conv_channels));
    bus(1'b1, ADCSQ_OFF_CTRL1, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, ADCSQ_OFF_CTRL4, 16'(k));
      chk("dma words", 16'(1 << k), 16'(dma_words_per_input));
    end
    bus(1'b1, ADCSQ_OFF_CH13, 16'h0005);
    chk("ch13 pos base", 16'h0003, 16'(ch13_pos_base));
    chk("ch13 neg inputs", 16'h0001, 16'(ch13_neg_inputs));
    bus(1'b1, ADCSQ_OFF_CH13, 16'h0006);
    chk("ch13 reserved", 16'h0001, 16'(ch13_neg_rsvd));
    bus(1'b1, ADCSQ_OFF_CH13, 16'h0000);
    bus(1'b1, ADCSQ_OFF_CH0, 16'h0088);
    chk("ch0 pos", 16'h0008, 16'(ch0_pos_input));
    chk("ch0 neg", 16'h0001, 16'(ch0_neg_input_one));
    // Scan over inputs 2, 5 and 7, split fill, an event every fourth conversion.
    bus(1'b1, ADCSQ_OFF_CH0, 16'h0002);
    bus(1'b1, ADCSQ_OFF_SCAN, 16'h00A4);
    bus(1'b1, ADCSQ_OFF_CTRL3, 16'h0200);
    bus(1'b1, ADCSQ_OFF_CTRL2, 16'h040E);
    run(12);
    for (int i = 0; i < 12 && i < pos_q.size(); i++) begin
      chk("scan input", 16'(i % 4 == 1 ? 5 : i % 4 == 2 ? 7 : 2), 16'(pos_q[i]));
      chk("low ref", 16'(i % 4 == 2), 16'(lr_q[i]));
    end
    chk("scan restart", 16'h0002, 16'(pos_q[4]));
    chk("events", 16'h0003, 16'(event_count - ev0));
    chk("fill half", 16'h0001, 16'(rd[0]));
    chk("result slot", 16'h0008, 16'(result_slot));
    // Alternate sets without scan, an event every second conversion.
    bus(1'b1, ADCSQ_OFF_CH0, 16'h0603);
    bus(1'b1, ADCSQ_OFF_CTRL2, 16'h0005);
    run(4);
    for (int i = 0; i < 4 && i < pos_q.size(); i++) begin
      chk("alternate input", 16'(i % 2 == 0 ? 3 : 6), 16'(pos_q[i]));
    end
    chk("events alt", 16'h0002, 16'(event_count - ev0));
    chk("fill half off", 16'h0000, 16'(rd[0]));
    chk("result slot low", 16'h0000, 16'(result_slot));
    chk("conv period", 16'h0008, 16'(cs_t[1] - cs_t[0]));
    // Every conversion an event, divider on the system clock.
    bus(1'b1, ADCSQ_OFF_CTRL2, 16'h0000);
    bus(1'b1, ADCSQ_OFF_CTRL3, 16'h0203);
    run(3);
    chk("events each", 16'h0003, 16'(event_count - ev0));
    chk("conv period div", 16'h0018, 16'(cs_t[2] - cs_t[1]));
    // RC source selected with the RC clock stopped: nothing may convert.
    @(posedge mclk);
    rc_en <= 1'b0;
    bus(1'b1, ADCSQ_OFF_CTRL3, 16'h8200);
    pos_q.delete();
    @(posedge mclk);
    auto_en <= 1'b1;
    repeat (300) @(negedge mclk);
    chk("rc stopped", 16'h0000, 16'(pos_q.size()));
    @(posedge mclk);
    auto_en <= 1'b0;
    rc_en <= 1'b1;
    run(2);
    summarize();
  end
endmodule
